/* inc/fwr_pkg.sv */
// Constants shared by the flash status polling controller modules
package fwr_pkg;
  localparam int          ADDR_W     = 19;         // Flash address width
  localparam int          DATA_W     = 8;          // Flash data width
  // Unlock and command words
  localparam logic [18:0] UNLK_A1    = 19'h00555;
  localparam logic [18:0] UNLK_A2    = 19'h002AA;
  localparam logic [7:0]  UNLK_D1    = 8'hAA;
  localparam logic [7:0]  UNLK_D2    = 8'h55;
  localparam logic [7:0]  CODE_PROG  = 8'hA0;
  localparam logic [7:0]  CODE_ERASE = 8'h80;
  localparam logic [7:0]  CODE_CHIP  = 8'h10;
  localparam logic [7:0]  CODE_SECT  = 8'h30;
  localparam logic [7:0]  CODE_SUSP  = 8'hB0;
  localparam logic [7:0]  CODE_RESUM = 8'h30;
  localparam logic [7:0]  CODE_RESET = 8'hF0;
  // Status bit positions on the data bus
  localparam int          POLL_POS   = 7;          // completion_poll_bit
  localparam int          TGL1_POS   = 6;          // first_toggle_bit
  localparam int          TOUT_POS   = 5;          // timeout_failure_bit
  localparam int          WIN_POS    = 3;          // erase_window_bit
  localparam int          TGL2_POS   = 2;          // sector_toggle_bit
  // User status vector positions
  localparam int          ST_FAIL    = 0;
  localparam int          ST_WINDOW  = 1;
  localparam int          ST_ERASING = 2;
  localparam int          ST_SUSP    = 3;
  // Timing
  localparam int          CLK_MHZ    = 20;
  localparam int          STRB_NS    = 100;        // Least strobe low time
  localparam int          STRB_CYC   = (STRB_NS * CLK_MHZ + 999) / 1000;
  localparam int          SYNC_CYC   = 2;          // Input synchroniser depth
  localparam int          WIN_US     = 80;         // Safe sector add spacing
  localparam int          WIN_CYC    = WIN_US * CLK_MHZ;
  localparam logic [3:0]  STRB_LAST  = 4'(STRB_CYC + SYNC_CYC - 1);
  localparam logic [10:0] WIN_LAST   = 11'(WIN_CYC - 1);
  // User operations
  typedef logic [3:0] fwr_op_t;
  localparam fwr_op_t     OP_READ    = 4'h0;
  localparam fwr_op_t     OP_PROG    = 4'h1;
  localparam fwr_op_t     OP_CHIP    = 4'h2;
  localparam fwr_op_t     OP_SECT    = 4'h3;
  localparam fwr_op_t     OP_ADDS    = 4'h4;
  localparam fwr_op_t     OP_SUSP    = 4'h5;
  localparam fwr_op_t     OP_RESUM   = 4'h6;
  localparam fwr_op_t     OP_RESET   = 4'h7;
  localparam fwr_op_t     OP_WAIT    = 4'h8;
endpackage : fwr_pkg

/* inc/fwr_bus_if.sv */
// Cycle request carrier between sequencer and bus cycle engine
interface fwr_bus_if;
  logic        req;    // One-cycle cycle request
  logic        wr;     // High for write cycle
  logic [18:0] addr;   // Cycle address
  logic [7:0]  wdata;  // Write data
  logic        done;   // One-cycle completion pulse
  logic [7:0]  rdata;  // Read data, valid with done
  modport ctl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fwr_bus_if

/* core/fwr_cycle.sv */
// Bus cycle engine: one flash read or write strobe per request
module fwr_cycle (
  input  wire logic  clk,
  input  wire logic  rst_n,
  fwr_bus_if.eng     bus,
  output logic [18:0] pin_addr,
  output logic [7:0]  pin_dq_o,
  output logic        pin_dq_oe,
  input  wire logic [7:0] pin_dq_i,
  output logic        pin_ce_n,
  output logic        pin_oe_n,
  output logic        pin_we_n
);
  typedef enum logic [3:0] {
    E_IDLE  = 4'b0001,
    E_SETUP = 4'b0010,
    E_STRB  = 4'b0100,
    E_HOLD  = 4'b1000
  } fwr_eng_e;

  fwr_eng_e   st_r;         // Engine state
  logic [3:0] cnt_r;        // Strobe length counter
  logic [7:0] dq_s1_r;      // Synchroniser first stage
  logic [7:0] dq_s2_r;      // Synchroniser second stage
  logic       wr_r;         // Current cycle is a write

  // Pin data passes two flops before anything looks at it
  always_ff @(posedge clk) begin
    dq_s1_r <= pin_dq_i;
    dq_s2_r <= dq_s1_r;
  end

  // Cycle sequencing; strobe held long enough to cover the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= E_IDLE;
      cnt_r     <= 4'h0;
      wr_r      <= 1'b0;
      pin_addr  <= 19'h00000;
      pin_dq_o  <= 8'h00;
      pin_dq_oe <= 1'b0;
      pin_ce_n  <= 1'b1;
      pin_oe_n  <= 1'b1;
      pin_we_n  <= 1'b1;
      bus.done  <= 1'b0;
      bus.rdata <= 8'h00;
    end else begin
      bus.done <= 1'b0;
      case (st_r)
        E_IDLE: begin
          // Address and data set up one cycle ahead of the strobe
          if (bus.req) begin
            wr_r      <= bus.wr;
            pin_addr  <= bus.addr;
            pin_dq_o  <= bus.wdata;
            pin_dq_oe <= bus.wr;
            st_r      <= E_SETUP;
          end
        end
        E_SETUP: begin
          pin_ce_n <= 1'b0;
          pin_we_n <= !wr_r;
          pin_oe_n <= wr_r;
          cnt_r    <= 4'h0;
          st_r     <= E_STRB;
        end
        E_STRB: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == fwr_pkg::STRB_LAST) begin
            // Rising strobe edge latches write data, ends a read cycle
            bus.rdata <= dq_s2_r;
            pin_ce_n  <= 1'b1;
            pin_oe_n  <= 1'b1;
            pin_we_n  <= 1'b1;
            st_r      <= E_HOLD;
          end
        end
        E_HOLD: begin
          // Data held one cycle past the strobe, then released
          pin_dq_oe <= 1'b0;
          bus.done  <= 1'b1;
          st_r      <= E_IDLE;
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end
endmodule : fwr_cycle

/* core/fwr_ctrl.sv */
// Flash command sequencer with status polling on the data bus
//
// Overview of operation
// - Host polls at the programmed address.
// - Host polls inside an erase-selected sector.
// - Trust full data only on next read.
// - After timeout, host writes reset command.
// - Host checks window bit around added sectors.
// - Combine both toggle bits for sector state.
// - Reread toggle after seeing timeout bit.
module fwr_ctrl (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CMD_VALID,
  input  wire logic [3:0]  CMD_OP,
  input  wire logic [18:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_DATA,
  output logic             CMD_READY,
  output logic             DONE,
  output logic [7:0]       RDATA,
  output logic [3:0]       STATUS,
  output logic [18:0]      F_ADDR,
  output logic [7:0]       F_DQ_O,
  output logic             F_DQ_OE,
  input  wire logic [7:0]  F_DQ_I,
  output logic             F_CE_N,
  output logic             F_OE_N,
  output logic             F_WE_N
);
  typedef enum logic [8:0] {
    S_IDLE = 9'b000000001,
    S_PRE  = 9'b000000010,
    S_WR   = 9'b000000100,
    S_RD1  = 9'b000001000,
    S_RD2  = 9'b000010000,
    S_EVAL = 9'b000100000,
    S_FIN  = 9'b001000000,
    S_RST  = 9'b010000000,
    S_DONE = 9'b100000000
  } fwr_st_e;

  fwr_bus_if bus ();                 // Link to the cycle engine

  fwr_st_e         st_r;             // Sequencer state
  fwr_pkg::fwr_op_t op_r;            // Latched operation
  logic [18:0]     addr_r;           // Target / poll address
  logic [7:0]      data_r;           // Program data
  logic [2:0]      step_r;           // Command word index
  logic            issued_r;         // Cycle request outstanding
  logic [7:0]      first_r;          // First read of a poll pair
  logic [7:0]      second_r;         // Second read of a poll pair
  logic            retry_r;          // Timeout seen once already
  logic [10:0]     win_r;            // Cycles since last sector erase or add
  logic            win_old;          // Spacing past the safe window
  logic            tgl1;             // First toggle bit moved
  logic            tgl2;             // Sector toggle bit moved
  logic [26:0]     word;             // Current command address, data
  logic [2:0]      last_step;        // Index of final command word

  // Command words per operation and step
  function automatic logic [26:0] seq_word(
      input logic [3:0] op, input logic [2:0] step,
      input logic [18:0] a, input logic [7:0] d);
    logic [7:0] code;
    code = (op == fwr_pkg::OP_PROG) ? fwr_pkg::CODE_PROG
                                    : fwr_pkg::CODE_ERASE;
    case (op)
      fwr_pkg::OP_ADDS:  seq_word = {a, fwr_pkg::CODE_SECT};
      fwr_pkg::OP_SUSP:  seq_word = {a, fwr_pkg::CODE_SUSP};
      fwr_pkg::OP_RESUM: seq_word = {a, fwr_pkg::CODE_RESUM};
      fwr_pkg::OP_RESET: seq_word = {a, fwr_pkg::CODE_RESET};
      default: begin
        case (step)
          3'h0, 3'h3: seq_word = (op == fwr_pkg::OP_PROG && step == 3'h3)
                       ? {a, d} : {fwr_pkg::UNLK_A1, fwr_pkg::UNLK_D1};
          3'h1, 3'h4: seq_word = {fwr_pkg::UNLK_A2, fwr_pkg::UNLK_D2};
          3'h2:       seq_word = {fwr_pkg::UNLK_A1, code};
          default:    seq_word = (op == fwr_pkg::OP_CHIP)
                       ? {fwr_pkg::UNLK_A1, fwr_pkg::CODE_CHIP}
                       : {a, fwr_pkg::CODE_SECT};
        endcase
      end
    endcase
  endfunction : seq_word

  // Word selection and poll-pair comparison
  always_comb begin
    word      = seq_word(op_r, step_r, addr_r, data_r);
    last_step = (op_r == fwr_pkg::OP_PROG) ? 3'h3 :
                (op_r == fwr_pkg::OP_CHIP ||
                 op_r == fwr_pkg::OP_SECT) ? 3'h5 : 3'h0;
    // toggles compared across two completed reads
    tgl1      = first_r[fwr_pkg::TGL1_POS] ^ second_r[fwr_pkg::TGL1_POS];
    tgl2      = first_r[fwr_pkg::TGL2_POS] ^ second_r[fwr_pkg::TGL2_POS];
    win_old   = (win_r == fwr_pkg::WIN_LAST);
  end

  // Time since the last sector erase write, saturating
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      win_r <= fwr_pkg::WIN_LAST;
    end else if (st_r == S_WR && bus.done && step_r == last_step &&
                 (op_r == fwr_pkg::OP_SECT || op_r == fwr_pkg::OP_ADDS)) begin
      win_r <= 11'h000;
    end else if (!win_old) begin
      win_r <= win_r + 11'h001;
    end
  end

  // Main sequencer
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r      <= S_IDLE;
      op_r      <= fwr_pkg::OP_READ;
      addr_r    <= 19'h00000;
      data_r    <= 8'h00;
      step_r    <= 3'h0;
      issued_r  <= 1'b0;
      first_r   <= 8'h00;
      second_r  <= 8'h00;
      retry_r   <= 1'b0;
      bus.req   <= 1'b0;
      bus.wr    <= 1'b0;
      bus.addr  <= 19'h00000;
      bus.wdata <= 8'h00;
      CMD_READY <= 1'b0;
      DONE      <= 1'b0;
      RDATA     <= 8'h00;
      STATUS    <= 4'h0;
    end else begin
      bus.req <= 1'b0;
      DONE    <= 1'b0;
      case (st_r)
        S_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            op_r      <= CMD_OP;
            addr_r    <= CMD_ADDR;
            data_r    <= CMD_DATA;
            step_r    <= 3'h0;
            retry_r   <= 1'b0;
            issued_r  <= 1'b0;
            STATUS    <= 4'h0;
            // window checked first unless adds are closely spaced
            if (CMD_OP == fwr_pkg::OP_READ)
              st_r <= S_FIN;
            else if (CMD_OP == fwr_pkg::OP_WAIT)
              st_r <= S_RD1;
            else if (CMD_OP == fwr_pkg::OP_ADDS && win_old)
              st_r <= S_PRE;
            else
              st_r <= S_WR;
          end
        end
        S_PRE: begin
          // a closed window would make the add pointless
          if (!issued_r) begin
            bus.req  <= 1'b1;
            bus.wr   <= 1'b0;
            bus.addr <= addr_r;
            issued_r <= 1'b1;
          end else if (bus.done) begin
            issued_r <= 1'b0;
            if (bus.rdata[fwr_pkg::WIN_POS]) begin
              STATUS[fwr_pkg::ST_WINDOW] <= 1'b1;
              st_r <= S_DONE;
            end else begin
              st_r <= S_WR;
            end
          end
        end
        S_WR: begin
          if (!issued_r) begin
            bus.req   <= 1'b1;
            bus.wr    <= 1'b1;
            bus.addr  <= word[26:8];
            bus.wdata <= word[7:0];
            issued_r  <= 1'b1;
          end else if (bus.done) begin
            issued_r <= 1'b0;
            step_r   <= step_r + 3'h1;
            if (step_r == last_step) begin
              // status polling starts right after the last strobe; resume and reset finish there instead
              if (op_r == fwr_pkg::OP_RESUM || op_r == fwr_pkg::OP_RESET)
                st_r <= S_DONE;
              else
                st_r <= S_RD1;
            end
          end
        end
        S_RD1, S_RD2: begin
          // poll at the target address; inside the erase sector
          if (!issued_r) begin
            bus.req  <= 1'b1;
            bus.wr   <= 1'b0;
            bus.addr <= addr_r;
            issued_r <= 1'b1;
          end else if (bus.done) begin
            issued_r <= 1'b0;
            first_r  <= (st_r == S_RD1) ? bus.rdata : first_r;
            second_r <= bus.rdata;
            st_r     <= (st_r == S_RD1) ? S_RD2 : S_EVAL;
          end
        end
        S_EVAL: begin
          // both toggles moving give erasing; sector toggle alone gives suspended sector
          STATUS[fwr_pkg::ST_ERASING] <= tgl1 & tgl2;
          STATUS[fwr_pkg::ST_SUSP]    <= !tgl1 & tgl2;
          STATUS[fwr_pkg::ST_WINDOW]  <= second_r[fwr_pkg::WIN_POS];
          if (op_r == fwr_pkg::OP_SECT || op_r == fwr_pkg::OP_ADDS) begin
            // accepted if toggling; window high after add is a miss
            STATUS[fwr_pkg::ST_FAIL] <= !tgl1 ||
              (op_r == fwr_pkg::OP_ADDS && second_r[fwr_pkg::WIN_POS]);
            st_r <= S_DONE;
          end else if (!tgl1) begin
            // one more read for fully valid data
            st_r <= S_FIN;
          end else if (second_r[fwr_pkg::TOUT_POS]) begin
            // reread once, toggle may stop with the timeout bit
            if (retry_r) begin
              STATUS[fwr_pkg::ST_FAIL] <= 1'b1;
              st_r <= S_RST;
            end else begin
              retry_r <= 1'b1;
              st_r    <= S_RD1;
            end
          end else begin
            st_r <= S_RD1;
          end
        end
        S_FIN: begin
          if (!issued_r) begin
            bus.req  <= 1'b1;
            bus.wr   <= 1'b0;
            bus.addr <= addr_r;
            issued_r <= 1'b1;
          end else if (bus.done) begin
            issued_r <= 1'b0;
            RDATA    <= bus.rdata;
            // a bit that would not take shows as a mismatch
            if (op_r == fwr_pkg::OP_PROG && bus.rdata != data_r)
              STATUS[fwr_pkg::ST_FAIL] <= 1'b1;
            st_r <= S_DONE;
          end
        end
        S_RST: begin
          // reset command after a timeout failure
          if (!issued_r) begin
            bus.req   <= 1'b1;
            bus.wr    <= 1'b1;
            bus.addr  <= addr_r;
            bus.wdata <= fwr_pkg::CODE_RESET;
            issued_r  <= 1'b1;
          end else if (bus.done) begin
            issued_r <= 1'b0;
            st_r     <= S_DONE;
          end
        end
        S_DONE: begin
          DONE <= 1'b1;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Pin-level cycle engine
  fwr_cycle u_cycle (
    .clk       (CLK),
    .rst_n     (RSTN),
    .bus       (bus),
    .pin_addr  (F_ADDR),
    .pin_dq_o  (F_DQ_O),
    .pin_dq_oe (F_DQ_OE),
    .pin_dq_i  (F_DQ_I),
    .pin_ce_n  (F_CE_N),
    .pin_oe_n  (F_OE_N),
    .pin_we_n  (F_WE_N)
  );
endmodule : fwr_ctrl

/* tb/fwr_ctrl_properties.sv */
// Concurrent checks on the flash controller ports
module fwr_ctrl_properties (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CMD_VALID,
  input wire logic [3:0]  CMD_OP,
  input wire logic [18:0] CMD_ADDR,
  input wire logic        CMD_READY,
  input wire logic        DONE,
  input wire logic [3:0]  STATUS,
  input wire logic [18:0] F_ADDR,
  input wire logic        F_DQ_OE,
  input wire logic        F_CE_N,
  input wire logic        F_OE_N,
  input wire logic        F_WE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] addr_r;  // Poll address of the op in flight
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Remember where the op must poll
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      addr_r <= 19'h00000;
    end else if (CMD_VALID && CMD_READY) begin
      addr_r <= CMD_ADDR;
    end
  end
  strb_width_a:
    assert property ($fell(F_CE_N) |-> !F_CE_N [*4] ##1 F_CE_N)
      else $error("Strobe not four cycles low");
  strb_pair_a:
    assert property ($fell(F_CE_N) |-> $fell(F_OE_N) != $fell(F_WE_N))
      else $error("Chip select without one strobe");
  wr_drive_a:
    assert property (!F_WE_N |-> F_DQ_OE)
      else $error("Write strobe with bus released");
  rd_release_a:
    assert property (!F_OE_N |-> !F_DQ_OE)
      else $error("Read strobe while driving bus");
  addr_hold_a:
    assert property (!F_CE_N && !$fell(F_CE_N) |-> $stable(F_ADDR))
      else $error("Address moved inside a cycle");
  rd_addr_a:
    assert property (!F_OE_N |-> F_ADDR == addr_r)
      else $error("Read away from the poll address");
  done_pulse_a:
    assert property (DONE |=> !DONE)
      else $error("Done longer than one cycle");
  ready_drop_a:
    assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
      else $error("Ready stayed high after take");
  read_lat_a:
    assert property (CMD_VALID && CMD_READY && CMD_OP == fwr_pkg::OP_READ
                     |-> ##[4:16] DONE)
      else $error("Read op late");
  // Main outcomes seen
  fail_c: cover property (DONE && STATUS[fwr_pkg::ST_FAIL]);
  susp_c: cover property (DONE && STATUS[fwr_pkg::ST_SUSP]);
  win_c:  cover property (DONE && STATUS[fwr_pkg::ST_WINDOW]);
endmodule : fwr_ctrl_properties

bind fwr_ctrl fwr_ctrl_properties i_fwr_ctrl_properties (.CLK, .RSTN,
  .CMD_VALID, .CMD_OP, .CMD_ADDR, .CMD_READY, .DONE, .STATUS, .F_ADDR,
  .F_DQ_OE, .F_CE_N, .F_OE_N, .F_WE_N);

/* tb/fwr_flash_model.sv */
// Behavioural flash device with embedded status reporting
module fwr_flash_model #(
  parameter int BUSY_RD  = 6,    // Status reads before an op ends
  parameter int PROT_SEC = 7,    // Write-protected sector
  parameter int WIN_NS   = 80000 // Sector add acceptance time-out
) (
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq_o,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic [7:0]       dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];     // Programmed bytes
  logic [7:0] blank = 8'h00; // Erased sectors
  logic [7:0] esel  = 8'h00; // Sectors selected for erase
  logic [7:0] pd    = 8'h00; // Datum being programmed
  logic [7:0] rv    = 8'h00; // Value of the current read
  int         hq[$];         // Write history, address and data
  int         busy  = 0;     // Reads left in the running op
  bit         prog, bad, fail, ers, susp, win, t6, t2;
  realtime    t_win;         // Last sector command time
  function automatic logic [7:0] arr(input logic [18:0] a);
    if (mem.exists(a)) return mem[a];
    return blank[a[18:16]] ? 8'hFF : a[7:0] ^ 8'h5A;
  endfunction : arr
  function automatic bit hw(input int k, input int v);
    return hq.size() >= k && hq[hq.size() - k] == v;
  endfunction : hw
  function automatic bit wo();
    return win && $realtime - t_win < WIN_NS;
  endfunction : wo
  always @(posedge we_n) begin
    hq.push_back(int'({addr, dq_o}));
    if (prog) begin
      // Only reset is heard, after a failure
      if (fail && dq_o == 8'hF0) begin
        prog = 0;
        fail = 0;
      end
    end else if (ers && !susp && dq_o == 8'hB0) begin
      susp = 1;
      win  = 0;
    end else if (ers && !susp && !wo()) begin
      // Running erase ignores the rest
    end else if (dq_o == 8'h30 && ers && !susp) begin
      esel[addr[18:16]] |= addr[18:16] != PROT_SEC;
      t_win = $realtime;
    end else if (dq_o == 8'h30 && susp) begin
      susp = 0;
    end else if (hw(4, 27'h55580) && (dq_o == 8'h30 || dq_o == 8'h10)) begin
      esel = (dq_o == 8'h10) ? 8'hFF : 8'h00;
      esel[addr[18:16]] |= dq_o == 8'h30;
      esel[PROT_SEC] = 1'b0;
      ers   = 1;
      win   = dq_o == 8'h30;
      t_win = $realtime;
      busy  = BUSY_RD;
    end else if (hw(2, 27'h555A0) && hw(3, 27'h2AA55)) begin
      prog = 1;
      pd   = dq_o;
      busy = BUSY_RD;
      bad  = addr[18:16] != PROT_SEC && (dq_o & ~arr(addr)) != 8'h00;
      if (addr[18:16] != PROT_SEC && !bad) mem[addr] = dq_o;
    end
  end
  always @(negedge oe_n) begin
    if (prog)
      rv = {~pd[7], t6, fail, 5'h00};
    else if (ers && !susp)
      rv = {1'b0, t6, 2'b00, !wo(), t2, 2'b00};
    else if (susp && esel[addr[18:16]])
      rv = {1'b1, t6, 3'b000, t2, 2'b00};
    else
      rv = arr(addr);
  end
  // toggles and progress once per read
  always @(posedge oe_n) begin
    t6 ^= prog || (ers && !susp);
    t2 ^= ers && esel[addr[18:16]] && !prog;
    if (busy > 0 && (prog || (!susp && !wo())))
      busy--;
    if (busy == 0 && prog && !fail) begin
      fail = bad;
      prog = bad;
    end
    if (busy == 0 && ers && !susp && !wo()) begin
      blank |= esel;
      ers = 0;
    end
  end
  // Released bus shows the inverse, never a stale value
  assign dq_i = (!ce_n && !oe_n) ? rv : ~rv;
endmodule : fwr_flash_model

/* tb/test_fwr_ctrl.sv */
// Self-checking bench for the flash status polling controller
module test_fwr_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 4000; // Cycles allowed for one op
  logic        CLK = 1'b0, RSTN = 1'b0, CMD_VALID = 1'b0;
  logic [3:0]  CMD_OP = 4'h0;
  logic [18:0] CMD_ADDR = 19'h00000;
  logic [7:0]  CMD_DATA = 8'h00;
  logic        CMD_READY, DONE, F_DQ_OE, F_CE_N, F_OE_N, F_WE_N;
  logic [7:0]  RDATA, F_DQ_O, F_DQ_I;
  logic [3:0]  STATUS;
  logic [18:0] F_ADDR, a;
  logic [7:0]  d;
  logic [7:0]  rm [int];        // Reference array contents
  bit   [7:0]  erased = 8'h00;  // Reference erased sectors
  int          fail_count = 0;
  int          checks_done = 0;
  fwr_ctrl i_fwr_ctrl (.CLK, .RSTN, .CMD_VALID, .CMD_OP, .CMD_ADDR,
    .CMD_DATA, .CMD_READY, .DONE, .RDATA, .STATUS, .F_ADDR, .F_DQ_O,
    .F_DQ_OE, .F_DQ_I, .F_CE_N, .F_OE_N, .F_WE_N);
  fwr_flash_model i_fwr_flash_model (.addr(F_ADDR), .dq_o(F_DQ_O),
    .ce_n(F_CE_N), .oe_n(F_OE_N), .we_n(F_WE_N), .dq_i(F_DQ_I));
  // 20 MHz clock
  initial forever #25 CLK = ~CLK;
  function automatic logic [7:0] ex(input logic [18:0] x);
    if (rm.exists(x)) return rm[x];
    return erased[x[18:16]] ? 8'hFF : x[7:0] ^ 8'h5A;
  endfunction : ex
  task automatic chk_d(input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED RDATA expected %h seen %h", e, s);
    end
  endtask : chk_d
  task automatic chk_s(input int b, input logic e);
    checks_done++;
    if (STATUS[b] !== e) begin
      fail_count++;
      $display("CHECK FAILED STATUS%0d expected %b seen %b", b, e, STATUS[b]);
    end
  endtask : chk_s
  // One user op, waiting for its done pulse
  task automatic op(input fwr_pkg::fwr_op_t o, input logic [18:0] x,
                    input logic [7:0] y);
    int n;
    n = 0;
    while (CMD_READY !== 1'b1 && n < 20) begin
      @(posedge CLK);
      #1;
      n++;
    end
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_OP    <= o;
    CMD_ADDR  <= x;
    CMD_DATA  <= y;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (DONE !== 1'b1 && n < LIMIT);
    if (DONE !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED DONE expected 1 seen %b", DONE);
    end
  endtask : op
  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog sized well past the whole run
  initial begin
    repeat (40000) @(posedge CLK);
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h8140));
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) begin
      a = {3'($urandom_range(3)), 16'($urandom)};
      op(fwr_pkg::OP_READ, a, 8'h00);
      chk_d(ex(a), RDATA);
    end
    // Programs that only clear bits
    repeat (3) begin
      a = {3'h0, 16'($urandom)};
      d = ex(a) & 8'($urandom);
      op(fwr_pkg::OP_PROG, a, d);
      rm[a] = d;
      chk_s(fwr_pkg::ST_FAIL, 1'b0);
      chk_d(d, RDATA);
    end
    // Setting a cleared bit times out
    a = {3'h1, 8'($urandom), 8'h5A};
    op(fwr_pkg::OP_PROG, a, 8'h80 | 8'($urandom));
    chk_s(fwr_pkg::ST_FAIL, 1'b1);
    op(fwr_pkg::OP_RESET, a, 8'h00);
    op(fwr_pkg::OP_READ, a, 8'h00);
    chk_d(ex(a), RDATA);
    // Protected sector keeps its data
    a = {3'h7, 16'($urandom)};
    op(fwr_pkg::OP_PROG, a, ~ex(a));
    chk_s(fwr_pkg::ST_FAIL, 1'b1);
    chk_d(ex(a), RDATA);
    // Sector erase with a prompt added sector
    op(fwr_pkg::OP_SECT, 19'h40000, 8'h00);
    chk_s(fwr_pkg::ST_ERASING, 1'b1);
    op(fwr_pkg::OP_ADDS, 19'h50000, 8'h00);
    chk_s(fwr_pkg::ST_WINDOW, 1'b0);
    chk_s(fwr_pkg::ST_FAIL, 1'b0);
    op(fwr_pkg::OP_WAIT, 19'h40000, 8'h00);
    erased[5:4] = 2'b11;
    chk_d(8'hFF, RDATA);
    a = {3'h5, 16'($urandom)};
    op(fwr_pkg::OP_READ, a, 8'h00);
    chk_d(ex(a), RDATA);
    // Suspend, read elsewhere, resume
    op(fwr_pkg::OP_SECT, 19'h60000, 8'h00);
    op(fwr_pkg::OP_SUSP, 19'h60010, 8'h00);
    chk_s(fwr_pkg::ST_SUSP, 1'b1);
    chk_d(8'h80, RDATA & 8'h80);
    a = {3'h0, 16'($urandom)};
    op(fwr_pkg::OP_READ, a, 8'h00);
    chk_d(ex(a), RDATA);
    op(fwr_pkg::OP_RESUM, 19'h60000, 8'h00);
    op(fwr_pkg::OP_WAIT, 19'h60000, 8'h00);
    erased[6] = 1'b1;
    chk_d(8'hFF, RDATA);
    // Late add finds the window closed
    op(fwr_pkg::OP_SECT, 19'h40000, 8'h00);
    repeat (2000) @(posedge CLK);
    op(fwr_pkg::OP_ADDS, 19'h50000, 8'h00);
    chk_s(fwr_pkg::ST_WINDOW, 1'b1);
    op(fwr_pkg::OP_WAIT, 19'h40000, 8'h00);
    chk_d(8'hFF, RDATA);
    // Chip erase has no window
    op(fwr_pkg::OP_CHIP, 19'h00000, 8'h00);
    op(fwr_pkg::OP_WAIT, 19'h50000, 8'h00);
    chk_d(8'hFF, RDATA);
    wrap_up();
  end
endmodule : test_fwr_ctrl
